/* verilog/bli_pkg.sv */
// Package with the register map, field positions and timing constants of the bit-level I2C block.
package bli_pkg;

    // ==========================================================
    // Register map (byte addresses on APB)
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CONFIG = 8'hC8;
    localparam logic [7:0] ADDR_CTRL = 8'hCC;
    localparam logic [7:0] ADDR_DATA = 8'hD0;
    localparam logic [7:0] ADDR_STAT = 8'hD4;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CFG_SLAVE_ENABLE = 7;
    localparam int CFG_MREQ = 6;
    localparam int CFG_CLRTO = 5;
    localparam int CFG_TIMEOUT_TIMER_RUN = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Control write bits.
    localparam int CW_CXA = 7;
    localparam int CW_IDLE = 6;
    localparam int CW_CDR = 5;
    localparam int CW_CLEAR_ARB_LOSS = 4;
    localparam int CW_CLEAR_START_SEEN = 3;
    localparam int CW_CLEAR_STOP_SEEN = 2;
    localparam int CW_SEND_REPEATED_START = 1;
    localparam int CW_SEND_STOP = 0;
    // Control read bits.
    localparam int CR_RBIT = 7;
    localparam int CR_ATN = 6;
    localparam int CR_DATA_READY_FLAG = 5;
    localparam int CR_ARL = 4;
    localparam int CR_STR = 3;
    localparam int CR_STP = 2;
    localparam int CR_MASTER = 1;
    // Data register bit and private status bits.
    localparam int DAT_BIT = 7;
    localparam int ST_TOFLAG = 0;
    localparam int ST_XA = 1;
    localparam int ST_BUSY = 2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int MACHINE_CLKS = 6;
    localparam logic [3:0] MINCNT_SEL0 = 4'h5;
    localparam logic [3:0] MINCNT_SEL1 = 4'h6;
    localparam logic [3:0] MINCNT_SEL2 = 4'h7;
    localparam logic [3:0] MINCNT_SEL3 = 4'h4;
    localparam int TIMEOUT_MC = 1023;
    localparam int TIMEOUT_CLKS = TIMEOUT_MC * MACHINE_CLKS;

    typedef enum logic [1:0] {OP_NONE, OP_RSTART, OP_STOP} bli_op_type;
    typedef enum logic [1:0] {PH_IDLE, PH_START, PH_RUN} bli_phase_type;

endpackage : bli_pkg

/* verilog/bli_bit_i2c.sv */
// Bit-level I2C interface with APB register access, serviced by software one bit at a time.
`timescale 1ns/10ps

// What this block does
// - Clearing only data ready keeps SCL low while other flags pend.
// - Arbitration loss clears transmit-active automatically.
// - Lose arbitration when a sent 1 or restart reads SDA 0 at SCL rise.
// - Lose arbitration and flag start when another start cuts our 1.
// - Master loses arbitration if restart pre-empted or stop blocked.
// - Start seen at master or non-idle slave; idle slave just wakes.
// - Stop seen at master or non-idle slave only.
// - Become master when master request is set and the bus is free.
// - Master status drops on arbitration loss or stop without request.
// - Data write or restart/stop command sets transmit-active.
// - SDA driven low and arbitration loss set only while transmit-active.
// - Data read or clear-transmit-active command ends transmit-active.
// - Idle command makes slave ignore bus until next start.
// - Data ready clears on its command and any data register access.
// - SCL low time stretched while any flag is pending.
// - Repeated start: release SDA, wait min time after SCL rise, pull SDA.
// - The initial start is generated by hardware on gaining mastership.
// - Stop: hold SDA low, wait min time after SCL rise, release SDA.
// - Attention is the OR of the four event flags.
// - SCL rise captures SDA and sets data ready when enabled, except at idle slave.
// - A new transmit bit reaches SDA only while SCL is low.
// - Timeout timer runs during frames, cleared by SCL edges and conditions.
module bli_bit_i2c #(
    parameter int TIMEOUT_CLKS = bli_pkg::TIMEOUT_CLKS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bli_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);

    localparam int TO_W = $clog2(TIMEOUT_CLKS + 1);

    typedef struct packed {
        logic sclMeta, sclSync, sclLast, sdaMeta, sdaSync, sdaLast;
        logic slaveEn, masterReq, timerRun;
        logic [1:0] minSel;
        logic data_ready_flag, arb_loss_flag, str, stop_seen_flag, master, xa, rxBit, txBit;
        logic sdaLow, sclLow, idle, busy, toFlag, opStage;
        bli_pkg::bli_op_type op;
        bli_pkg::bli_phase_type phase;
        logic [7:0] minCnt;
        logic [TO_W-1:0] toCnt;
        logic [7:0] rdata;
        logic rerr;
    } bli_state_type;

    bli_state_type st_reg;
    bli_state_type st_next;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [7:0] minClocks(input logic [1:0] sel);
        logic [3:0] cnt;
        cnt = bli_pkg::MINCNT_SEL0;
        unique case (sel)
            2'h0: cnt = bli_pkg::MINCNT_SEL0;
            2'h1: cnt = bli_pkg::MINCNT_SEL1;
            2'h2: cnt = bli_pkg::MINCNT_SEL2;
            2'h3: cnt = bli_pkg::MINCNT_SEL3;
        endcase
        return 8'(cnt * bli_pkg::MACHINE_CLKS);
    endfunction : minClocks

    function automatic logic isAddr(input logic [bli_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction : isAddr

    logic sclRise, sclFall, startDet, stopDet, enabled, idleSlave, attn;
    logic access, wrCfg, wrCtrl, wrData, rdData, arlSet, minDone;
    logic [7:0] minClks;

    assign sclRise = st_reg.sclSync & ~st_reg.sclLast;
    assign sclFall = ~st_reg.sclSync & st_reg.sclLast;
    assign startDet = st_reg.sclSync & st_reg.sclLast & st_reg.sdaLast & ~st_reg.sdaSync;
    assign stopDet = st_reg.sclSync & st_reg.sclLast & ~st_reg.sdaLast & st_reg.sdaSync;
    assign enabled = st_reg.slaveEn | st_reg.masterReq;
    assign idleSlave = st_reg.idle & ~st_reg.master;
    assign attn = st_reg.data_ready_flag | st_reg.arb_loss_flag | st_reg.str | st_reg.stop_seen_flag;
    assign access = psel & penable;
    assign wrCfg = access & pwrite & isAddr(paddr, bli_pkg::ADDR_CONFIG);
    assign wrCtrl = access & pwrite & isAddr(paddr, bli_pkg::ADDR_CTRL);
    assign wrData = access & pwrite & isAddr(paddr, bli_pkg::ADDR_DATA);
    assign rdData = access & ~pwrite & isAddr(paddr, bli_pkg::ADDR_DATA);
    assign minClks = minClocks(st_reg.minSel);
    assign minDone = st_reg.minCnt >= minClks;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        st_next = st_reg;
        arlSet = 1'h0;
        // Pin synchronisers: the meta stage feeds only the sync stage.
        st_next.sclMeta = sclIn;
        st_next.sclSync = st_reg.sclMeta;
        st_next.sclLast = st_reg.sclSync;
        st_next.sdaMeta = sdaIn;
        st_next.sdaSync = st_reg.sdaMeta;
        st_next.sdaLast = st_reg.sdaSync;
        if (st_reg.minCnt != 8'hFF) st_next.minCnt = st_reg.minCnt + 8'h01;

        // Software effects come first so that hardware sets below win.
        if (wrCfg) begin
            st_next.slaveEn = pwdata[bli_pkg::CFG_SLAVE_ENABLE];
            st_next.masterReq = pwdata[bli_pkg::CFG_MREQ];
            st_next.timerRun = pwdata[bli_pkg::CFG_TIMEOUT_TIMER_RUN];
            st_next.minSel = pwdata[1:0];
            if (pwdata[bli_pkg::CFG_CLRTO]) st_next.toFlag = 1'h0;
        end
        if (wrCtrl) begin
            if (pwdata[bli_pkg::CW_CXA]) st_next.xa = 1'h0;
            if (pwdata[bli_pkg::CW_IDLE]) st_next.idle = 1'h1;
            if (pwdata[bli_pkg::CW_CDR]) st_next.data_ready_flag = 1'h0;
            if (pwdata[bli_pkg::CW_CLEAR_ARB_LOSS]) st_next.arb_loss_flag = 1'h0;
            if (pwdata[bli_pkg::CW_CLEAR_START_SEEN]) st_next.str = 1'h0;
            if (pwdata[bli_pkg::CW_CLEAR_STOP_SEEN]) st_next.stop_seen_flag = 1'h0;
            if (pwdata[bli_pkg::CW_SEND_REPEATED_START]) begin
                st_next.xa = 1'h1;
                st_next.txBit = 1'h1;
                st_next.op = bli_pkg::OP_RSTART;
                st_next.opStage = 1'h0;
            end else if (pwdata[bli_pkg::CW_SEND_STOP]) begin
                st_next.xa = 1'h1;
                st_next.txBit = 1'h0;
                st_next.op = bli_pkg::OP_STOP;
                st_next.opStage = 1'h0;
            end
        end
        if (wrData) begin
            st_next.txBit = pwdata[bli_pkg::DAT_BIT];
            st_next.xa = 1'h1;
            st_next.data_ready_flag = 1'h0;
        end
        if (rdData) begin
            st_next.xa = 1'h0;
            st_next.data_ready_flag = 1'h0;
        end

        // Bus observation.
        if (sclRise) begin
            st_next.rxBit = st_reg.sdaSync;
            st_next.minCnt = 8'h00;
            if (enabled && !idleSlave) st_next.data_ready_flag = 1'h1;
            // A released SDA read back as 0 means another transmitter won.
            if (st_reg.xa && !st_reg.sdaLow && !st_reg.sdaSync) begin
                arlSet = 1'h1;
            end
        end
        if (sclFall) begin
            st_next.minCnt = 8'h00;
            // Someone else ended the high phase before our restart went out.
            if (st_reg.master && st_reg.op == bli_pkg::OP_RSTART && !st_reg.opStage) begin
                arlSet = 1'h1;
            end
        end
        if (startDet) begin
            st_next.busy = 1'h1;
            st_next.minCnt = 8'h00;
            if (enabled && !st_reg.sdaLow) begin
                if (idleSlave) begin
                    st_next.idle = 1'h0;
                end else begin
                    st_next.str = 1'h1;
                end
                if (st_reg.xa && st_reg.op == bli_pkg::OP_NONE) begin
                    arlSet = 1'h1;
                end
            end
        end
        if (stopDet) begin
            st_next.busy = 1'h0;
            // Our own stop is not reported back as a stop seen.
            if (enabled && !idleSlave && st_reg.op != bli_pkg::OP_STOP) begin
                st_next.stop_seen_flag = 1'h1;
            end
        end

        // Timeout supervision of a hung bus.
        if (!st_reg.timerRun || !enabled || !st_reg.busy || st_reg.sclSync != st_reg.sclLast
                || startDet || stopDet) begin
            st_next.toCnt = '0;
        end else if (st_reg.toCnt >= TO_W'(TIMEOUT_CLKS - 1)) begin
            st_next.toCnt = '0;
            st_next.toFlag = 1'h1;
            st_next.slaveEn = 1'h0;
            st_next.busy = 1'h0;
        end else begin
            st_next.toCnt = st_reg.toCnt + TO_W'(1);
        end

        // Master sequencing.
        unique case (st_reg.phase)
            bli_pkg::PH_IDLE: begin
                // A free bus also covers the idle slave waiting for the next start.
                if (st_reg.masterReq && enabled && !st_reg.busy && !st_reg.master) begin
                    st_next.master = 1'h1;
                    st_next.phase = bli_pkg::PH_START;
                    st_next.opStage = 1'h0;
                    st_next.minCnt = 8'h00;
                end
            end
            bli_pkg::PH_START: begin
                // Initial start comes from hardware, never from a command.
                if (minDone && st_reg.sclSync) begin
                    st_next.minCnt = 8'h00;
                    if (!st_reg.opStage) begin
                        st_next.xa = 1'h1;
                        st_next.txBit = 1'h0;
                        st_next.sdaLow = 1'h1;
                        st_next.opStage = 1'h1;
                    end else begin
                        st_next.sclLow = 1'h1;
                        // Holding SDA low past the SCL fall avoids a false stop.
                        st_next.txBit = 1'h1;
                        st_next.phase = bli_pkg::PH_RUN;
                    end
                end
            end
            bli_pkg::PH_RUN: begin
                if (st_reg.sclSync && !sclRise && minDone) begin
                    st_next.minCnt = 8'h00;
                    unique case (st_reg.op)
                        bli_pkg::OP_NONE: st_next.sclLow = 1'h1;
                        bli_pkg::OP_RSTART: begin
                            if (!st_reg.opStage) begin
                                st_next.sdaLow = 1'h1;
                                st_next.opStage = 1'h1;
                            end else begin
                                st_next.sclLow = 1'h1;
                                st_next.op = bli_pkg::OP_NONE;
                            end
                        end
                        bli_pkg::OP_STOP: begin
                            if (!st_reg.opStage) begin
                                st_next.sdaLow = 1'h0;
                                st_next.opStage = 1'h1;
                            end else if (!st_reg.sdaSync) begin
                                arlSet = 1'h1;
                            end else begin
                                st_next.op = bli_pkg::OP_NONE;
                                st_next.phase = bli_pkg::PH_IDLE;
                                st_next.xa = 1'h0;
                                st_next.busy = 1'h0;
                                if (!st_reg.masterReq) st_next.master = 1'h0;
                            end
                        end
                        default: st_next.op = bli_pkg::OP_NONE;
                    endcase
                end
            end
            default: st_next.phase = bli_pkg::PH_IDLE;
        endcase

        // SCL low phase: hold for the min time as master and while flags pend.
        if (!st_reg.sclSync && st_reg.phase != bli_pkg::PH_START) begin
            // The transmit bit only reaches SDA while SCL is low.
            st_next.sdaLow = st_next.xa & ~st_next.txBit;
            // A master holds SCL one more cycle after SDA moves, so data has setup time.
            st_next.sclLow = enabled && (attn || (st_reg.master && (!minDone
                || st_next.sdaLow != st_reg.sdaLow)));
        end

        if (arlSet && st_reg.xa) begin
            st_next.arb_loss_flag = 1'h1;
            st_next.xa = 1'h0;
            st_next.master = 1'h0;
            st_next.op = bli_pkg::OP_NONE;
            st_next.phase = bli_pkg::PH_IDLE;
        end
        if (!st_next.master && !st_next.sclLow) begin
            st_next.phase = bli_pkg::PH_IDLE;
        end
        if (!st_next.xa) begin
            st_next.sdaLow = 1'h0;
            st_next.op = bli_pkg::OP_NONE; // A dropped command must not mask a later stop.
        end
        if (!enabled) st_next.sclLow = 1'h0;

        // APB read data is captured in the setup cycle.
        if (psel && !penable) begin
            st_next.rerr = 1'h0;
            st_next.rdata = 8'h00;
            if (isAddr(paddr, bli_pkg::ADDR_CONFIG)) begin
                st_next.rdata[bli_pkg::CFG_SLAVE_ENABLE] = st_reg.slaveEn;
                st_next.rdata[bli_pkg::CFG_MREQ] = st_reg.masterReq;
                st_next.rdata[bli_pkg::CFG_TIMEOUT_TIMER_RUN] = st_reg.timerRun;
                st_next.rdata[1:0] = st_reg.minSel;
            end else if (isAddr(paddr, bli_pkg::ADDR_CTRL)) begin
                st_next.rdata[bli_pkg::CR_RBIT] = st_reg.rxBit;
                st_next.rdata[bli_pkg::CR_ATN] = attn;
                st_next.rdata[bli_pkg::CR_DATA_READY_FLAG] = st_reg.data_ready_flag;
                st_next.rdata[bli_pkg::CR_ARL] = st_reg.arb_loss_flag;
                st_next.rdata[bli_pkg::CR_STR] = st_reg.str;
                st_next.rdata[bli_pkg::CR_STP] = st_reg.stop_seen_flag;
                st_next.rdata[bli_pkg::CR_MASTER] = st_reg.master;
            end else if (isAddr(paddr, bli_pkg::ADDR_DATA)) begin
                st_next.rdata[bli_pkg::DAT_BIT] = st_reg.rxBit;
            end else if (isAddr(paddr, bli_pkg::ADDR_STAT)) begin
                st_next.rdata[bli_pkg::ST_TOFLAG] = st_reg.toFlag;
                st_next.rdata[bli_pkg::ST_XA] = st_reg.xa;
                st_next.rdata[bli_pkg::ST_BUSY] = st_reg.busy;
            end else begin
                st_next.rerr = 1'h1;
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.sclMeta <= 1'h1;
            st_reg.sclSync <= 1'h1;
            st_reg.sclLast <= 1'h1;
            st_reg.sdaMeta <= 1'h1;
            st_reg.sdaSync <= 1'h1;
            st_reg.sdaLast <= 1'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = {24'h000000, st_reg.rdata};
    assign pready = 1'h1;
    assign pslverr = access & st_reg.rerr;
    assign sclOut = 1'h0;
    assign sdaOut = 1'h0;
    assign sclOe = st_reg.sclLow;
    assign sdaOe = st_reg.sdaLow;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_xa_drop_arl: assert property ($rose(st_reg.arb_loss_flag) |-> !st_reg.xa)
        else $error("transmit-active still set after arbitration loss");
    chk_arl_needs_xa: assert property ($rose(st_reg.arb_loss_flag) |-> $past(st_reg.xa))
        else $error("arbitration loss set without transmit-active");
    chk_sda_needs_xa: assert property (st_reg.sdaLow |-> st_reg.xa)
        else $error("SDA driven low without transmit-active");
    chk_scl_stretch_hold: assert property (
        (!st_reg.sclSync && enabled && attn && st_reg.phase != bli_pkg::PH_START)
        |=> st_reg.sclLow)
        else $error("SCL not held low while flags pend");
    chk_data_ready_flag_on_rise: assert property (
        (sclRise && enabled && !idleSlave) |=> st_reg.data_ready_flag)
        else $error("data ready not set at SCL rise");
    chk_data_write_xa: assert property (wrData |=> (st_reg.xa || st_reg.arb_loss_flag))
        else $error("data write did not set transmit-active");
    chk_data_read_xa: assert property (rdData |=> !st_reg.xa)
        else $error("data read did not clear transmit-active");
    chk_cdr_clears: assert property (
        (wrCtrl && pwdata[bli_pkg::CW_CDR] && !sclRise) |=> !st_reg.data_ready_flag)
        else $error("data ready not cleared by command");
    chk_master_gain: assert property (
        (st_reg.phase == bli_pkg::PH_IDLE && st_reg.masterReq && enabled && !st_reg.busy
         && !st_reg.master) |=> st_reg.master ##1 st_reg.phase == bli_pkg::PH_START)
        else $error("master status not taken on free bus");
    chk_sda_low_time: assert property (
        ($rose(st_reg.sdaLow) && st_reg.phase == bli_pkg::PH_RUN && st_reg.op == bli_pkg::OP_NONE)
        |-> !$past(st_reg.sclSync))
        else $error("transmit bit applied while SCL high");

    cov_data_ready_flag: cover property ($rose(st_reg.data_ready_flag));
    cov_arl: cover property ($rose(st_reg.arb_loss_flag));
    cov_master: cover property ($rose(st_reg.master));
    cov_stop: cover property ($rose(st_reg.stop_seen_flag));

endmodule : bli_bit_i2c

/* bench/bli_bus_model.sv */
// Behavioural partner: another master that frames bits on SCL and SDA.
`timescale 1ns/10ps
module bli_bus_model (
    input wire logic clk_sys,
    input wire logic sclLine,
    output logic sclOeM = 1'h0,
    output logic sdaOeM = 1'h0
);
    // Set when a released SCL never comes back high within the bound.
    logic stuck = 1'h0;
    // One step lasts half a link period; releasing SCL waits out any stretch by the slave.
    task automatic drive(input logic sdaLow, input logic sclLow);
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        sdaOeM <= sdaLow;
        sclOeM <= sclLow;
        while (!sclLow && sclLine !== 1'h1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        if (!sclLow && n >= 5000) begin
            stuck <= 1'h1;
        end
    endtask : drive
    // Three steps of {sdaLow, sclLow}, the first one in the top bits.
    task automatic play(input logic [5:0] seq);
        for (int i = 2; i >= 0; i--) begin
            drive(seq[2*i+1], seq[2*i]);
        end
    endtask : play
endmodule : bli_bus_model

/* bench/bli_bit_i2c_tb.sv */
// Self-checking bench for the bit-level I2C block and its bus partner.
`timescale 1ns/10ps
module bli_bit_i2c_tb;
    logic clk_sys, sys_rst, psel, penable, pwrite;
    logic pready, pslverr, err, rdy, sclOut, sclOe, sdaOut, sdaOe, sclOeM, sdaOeM;
    logic [bli_pkg::ADDR_W-1:0] paddr;
    logic [7:0] r;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    int err_count = 0, n_compared = 0;
    // Write address, write data, read address, expected read byte.
    logic [31:0] rows [8] = '{32'hC8B1C891, 32'hC880C880, 32'hD000D402, 32'hCC80D400,
        32'hCC02D402, 32'hCC80D400, 32'hCC01D402, 32'hCC80D400};
    // Open-drain lines with pull-ups.
    wire logic sclLine = ~(sclOe | sclOeM);
    wire logic sdaLine = ~(sdaOe | sdaOeM);
    bli_bit_i2c #(.TIMEOUT_CLKS(3000)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
        .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
    bli_bus_model u_bus (.clk_sys(clk_sys), .sclLine(sclLine), .sclOeM(sclOeM),
        .sdaOeM(sdaOeM));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // The request stands until pready is seen high at a rising edge; data is taken there.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            {rdy, err} = {pready, pslverr};
            r = prdata[7:0];
            n++;
        end while (rdy !== 1'h1 && n < 20);
        psel <= 1'h0;
        penable <= 1'h0;
        if (rdy !== 1'h1) begin
            err_count++;
            final_report();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'h0, a, 8'h00);
        check(r, exp);
    endtask : rdc
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #300000;
        err_count++;
        final_report();
    end
    initial begin
        sys_rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        rdc(8'hC8, 8'h00);
        rdc(8'hD4, 8'h00);
        check({4'h0, sclOut, sdaOut, sclOe, sdaOe}, 8'h00);
        foreach (rows[i]) begin
            apb(1'h1, rows[i][31:24], rows[i][23:16]);
            rdc(rows[i][15:8], rows[i][7:0]);
        end
        u_bus.play(6'h2B);
        apb(1'h1, 8'hCC, 8'h1C);
        u_bus.play(6'h11);
        repeat (6) @(posedge clk_sys);
        check({7'h0, sclOe}, 8'h01);
        rdc(8'hCC, 8'hE0);
        rdc(8'hD0, 8'h80);
        repeat (4) @(posedge clk_sys);
        check({7'h0, sclOe}, 8'h00);
        u_bus.play(6'h3B);
        repeat (6) @(posedge clk_sys);
        rdc(8'hCC, 8'h60);
        apb(1'h1, 8'hCC, 8'h20);
        rdc(8'hCC, 8'h00);
        u_bus.play(6'h38);
        repeat (6) @(posedge clk_sys);
        rdc(8'hCC, 8'h64);
        apb(1'h1, 8'hCC, 8'h20);
        rdc(8'hCC, 8'h44);
        apb(1'h1, 8'hCC, 8'h04);
        rdc(8'hCC, 8'h00);
        apb(1'h1, 8'hCC, 8'h40);
        u_bus.play(6'h2B);
        repeat (6) @(posedge clk_sys);
        rdc(8'hCC, 8'h00);
        apb(1'h1, 8'hCC, 8'h40);
        u_bus.play(6'h38);
        repeat (6) @(posedge clk_sys);
        rdc(8'hCC, 8'h00);
        rdc(8'h00, 8'h00);
        check({7'h0, err}, 8'h01);
        // Master: hardware start, first bit clocked, then stretched on data ready.
        apb(1'h1, 8'hC8, 8'hC0);
        repeat (200) @(posedge clk_sys);
        check({7'h0, sclOe}, 8'h01);
        rdc(8'hCC, 8'hE2);
        apb(1'h1, 8'hC8, 8'h80);
        apb(1'h1, 8'hCC, 8'h21);
        repeat (100) @(posedge clk_sys);
        check({6'h0, sclOe, sdaOe}, 8'h00);
        rdc(8'hCC, 8'h60);
        rdc(8'hD4, 8'h00);
        check({7'h0, u_bus.stuck}, 8'h00);
        final_report();
    end
endmodule : bli_bit_i2c_tb
